// ### cogt_defines.svh
// register map constants for the channel offset and full-scale trim bank
`ifndef COGT_DEFINES_SVH
`define COGT_DEFINES_SVH
`define COGT_ADDR_W 4
`define COGT_ADDR_OFFSET 4'h2
`define COGT_ADDR_FULLSCALE 4'h3
`define COGT_OFFSET_RESET 16'h0000
`define COGT_FULLSCALE_RESET 16'h4000
`define COGT_SIGN_BIT 12
`define COGT_MAG_MSB 11
`define COGT_FS_MSB 14
`define COGT_MAG_MONO_BITS 9
`define COGT_FS_NOMINAL_LOW 15'h4000
`endif

// ### cogt_pkg.sv
// types for the channel offset and full-scale trim bank
package cogt_pkg;
    typedef logic [3:0] cogt_addr_t;
    typedef logic [15:0] cogt_word_t;
    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] fullscale;
        logic [15:0] rdata;
    } cogt_state_t;
endpackage

// ### cogt_trim_regs.sv
// trim register bank: offset and full-scale range settings for one channel
// What this block does
// - address 2 is offset register, resets zero
// - address 3 is full-scale range register
// - bit 12 selects offset sign, default positive
// - bits 11:0 give unsigned offset magnitude
// - offset magnitude reads zero after reset
// - bits 14:0 give full-scale range code
// - full-scale register resets to 4000 hex
// - midscale code equals nominal low range
// - only upper nine magnitude bits monotonic
`timescale 1ns/1ps
`include "cogt_defines.svh"
module cogt_trim_regs #(
    parameter int ADDR_W = `COGT_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire cogt_pkg::cogt_addr_t addr,
    input wire cogt_pkg::cogt_word_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output cogt_pkg::cogt_word_t rdata,
    output logic offset_sign,
    output logic [11:0] offset_magnitude,
    output logic [11:0] offset_magnitude_mono,
    output logic [14:0] fullscale_code,
    output logic fullscale_at_nominal
);
    import cogt_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking

    // only a 4-bit map is decoded; a wider bus would alias registers
    if (ADDR_W != 4)
    begin : g_addr_check
        $error("cogt_trim_regs supports only a 4-bit address");
    end

    cogt_state_t state_q;
    cogt_state_t state_d;
    logic fs_nom_q;
    logic fs_nom_d;

    always_comb
    begin
        state_d = state_q;
        state_d.rdata = 16'h0000;
        if (wr_en)
        begin
            case (addr)
                `COGT_ADDR_OFFSET: state_d.offset = wdata;
                `COGT_ADDR_FULLSCALE: state_d.fullscale = wdata;
                default: state_d.offset = state_q.offset;
            endcase
        end
        if (rd_en)
        begin
            // registers read back as written; reserved bits are not
            // forced because the writer keeps them zero
            case (addr)
                `COGT_ADDR_OFFSET: state_d.rdata = state_q.offset;
                `COGT_ADDR_FULLSCALE: state_d.rdata = state_q.fullscale;
                default: state_d.rdata = 16'h0000;
            endcase
        end
        // midscale flag computed from next value so it tracks the register
        fs_nom_d = (state_d.fullscale[`COGT_FS_MSB:0]
            == `COGT_FS_NOMINAL_LOW);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q.offset <= `COGT_OFFSET_RESET;
            state_q.fullscale <= `COGT_FULLSCALE_RESET;
            state_q.rdata <= 16'h0000;
            fs_nom_q <= 1'b1;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            fs_nom_q <= fs_nom_d;
        end
    end

    assign rdata = state_q.rdata;
    assign offset_sign = state_q.offset[`COGT_SIGN_BIT];
    assign offset_magnitude = state_q.offset[`COGT_MAG_MSB:0];
    // lower bits masked: only the upper nine steps are monotonic
    assign offset_magnitude_mono = {state_q.offset[`COGT_MAG_MSB:3],
        3'h0};
    assign fullscale_code = state_q.fullscale[`COGT_FS_MSB:0];
    assign fullscale_at_nominal = fs_nom_q;

    // qualified accesses seen by the checks; a strobe only counts while
    // the enable lets the bank advance
    logic acc_wr_ofs;
    logic acc_wr_fs;
    logic acc_wr_other;
    logic acc_rd_ofs;
    logic acc_rd_fs;
    logic acc_rd_other;
    logic acc_idle_wr;
    logic acc_idle_rd;

    assign acc_wr_ofs = clk_en && wr_en && addr == `COGT_ADDR_OFFSET;
    assign acc_wr_fs = clk_en && wr_en && addr == `COGT_ADDR_FULLSCALE;
    assign acc_wr_other = clk_en && wr_en && addr != `COGT_ADDR_OFFSET
        && addr != `COGT_ADDR_FULLSCALE;
    assign acc_rd_ofs = clk_en && rd_en && !wr_en
        && addr == `COGT_ADDR_OFFSET;
    assign acc_rd_fs = clk_en && rd_en && !wr_en
        && addr == `COGT_ADDR_FULLSCALE;
    assign acc_rd_other = clk_en && rd_en && addr != `COGT_ADDR_OFFSET
        && addr != `COGT_ADDR_FULLSCALE;
    assign acc_idle_wr = !(clk_en && wr_en);
    assign acc_idle_rd = clk_en && !rd_en;

    // reset values
    a_offset_reset: assert property (
        rst
        |=> (offset_magnitude == 12'h000 && !offset_sign))
        else $error("offset not zero after reset");

    a_sign_reset: assert property (
        rst
        |=> !offset_sign)
        else $error("sign not positive after reset");

    a_fs_reset: assert property (
        rst
        |=> fullscale_code == 15'h4000)
        else $error("full-scale not midscale after reset");

    a_nominal_reset: assert property (
        rst
        |=> fullscale_at_nominal)
        else $error("nominal flag low after reset");

    a_rdata_reset: assert property (
        rst
        |=> rdata == 16'h0000)
        else $error("read data not zero after reset");

    // writes land in the addressed register only
    a_offset_write: assert property (disable iff (rst)
        acc_wr_ofs
        |=> offset_magnitude == $past(wdata[11:0]))
        else $error("offset write lost");

    a_sign_write: assert property (disable iff (rst)
        acc_wr_ofs
        |=> offset_sign == $past(wdata[12]))
        else $error("sign write lost");

    a_fs_write: assert property (disable iff (rst)
        acc_wr_fs
        |=> fullscale_code == $past(wdata[14:0]))
        else $error("full-scale write lost");

    a_ofs_keeps_fs: assert property (disable iff (rst)
        acc_wr_ofs
        |=> $stable(fullscale_code))
        else $error("offset write hit full-scale");

    a_fs_keeps_ofs: assert property (disable iff (rst)
        acc_wr_fs
        |=> $stable(offset_magnitude) && $stable(offset_sign))
        else $error("full-scale write hit offset");

    a_fs_keeps_nominal: assert property (disable iff (rst)
        acc_wr_ofs
        |=> $stable(fullscale_at_nominal))
        else $error("offset write moved nominal flag");

    a_unmapped_write: assert property (disable iff (rst)
        acc_wr_other
        |=> $stable(offset_magnitude) && $stable(fullscale_code))
        else $error("unmapped write changed a trim");

    a_offset_write_full: assert property (disable iff (rst)
        acc_wr_ofs ##1 acc_idle_wr ##1 acc_rd_ofs
        |=> rdata == $past(wdata, 3))
        else $error("offset word not read back");

    a_fs_write_full: assert property (disable iff (rst)
        acc_wr_fs ##1 acc_idle_wr ##1 acc_rd_fs
        |=> rdata == $past(wdata, 3))
        else $error("full-scale word not read back");

    // registers hold between writes and freeze with the enable
    a_hold_value: assert property (disable iff (rst)
        acc_idle_wr
        |=> $stable(offset_magnitude) && $stable(fullscale_code))
        else $error("trim changed without write");

    a_hold_sign: assert property (disable iff (rst)
        acc_idle_wr
        |=> $stable(offset_sign))
        else $error("sign changed without write");

    a_hold_nominal: assert property (disable iff (rst)
        acc_idle_wr
        |=> $stable(fullscale_at_nominal))
        else $error("nominal flag changed without write");

    a_freeze_trims: assert property (disable iff (rst)
        !clk_en
        |=> $stable(offset_magnitude) && $stable(fullscale_code))
        else $error("trim moved while frozen");

    a_freeze_rdata: assert property (disable iff (rst)
        !clk_en
        |=> $stable(rdata))
        else $error("read data moved while frozen");

    a_read_keeps_ofs: assert property (disable iff (rst)
        acc_rd_ofs
        |=> $stable(offset_magnitude))
        else $error("read disturbed offset");

    a_read_keeps_sign: assert property (disable iff (rst)
        acc_rd_ofs
        |=> $stable(offset_sign))
        else $error("read disturbed sign");

    a_read_keeps_fs: assert property (disable iff (rst)
        acc_rd_fs
        |=> $stable(fullscale_code))
        else $error("read disturbed full-scale");

    // read data stand one cycle after the strobe, zero after an enabled cycle without one
    a_read_back: assert property (disable iff (rst)
        acc_rd_fs
        |=> rdata[14:0] == fullscale_code)
        else $error("full-scale readback wrong");

    a_sign_field: assert property (disable iff (rst)
        acc_rd_ofs
        |=> rdata[12:0] == {offset_sign, offset_magnitude})
        else $error("offset readback wrong");

    a_read_sign: assert property (disable iff (rst)
        acc_rd_ofs
        |=> rdata[12] == offset_sign)
        else $error("sign readback wrong");

    a_unmapped_read: assert property (disable iff (rst)
        acc_rd_other
        |=> rdata == 16'h0000)
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (disable iff (rst)
        acc_idle_rd
        |=> rdata == 16'h0000)
        else $error("read data outside read cycle");

    // the nominal flag follows the full-scale code
    a_nominal_flag: assert property (disable iff (rst)
        1'b1
        |-> fullscale_at_nominal == (fullscale_code == 15'h4000))
        else $error("nominal flag wrong");

    a_fs_write_nominal: assert property (disable iff (rst)
        acc_wr_fs
        |=> fullscale_at_nominal == ($past(wdata[14:0]) == 15'h4000))
        else $error("nominal flag missed write");

    a_read_fs_nominal: assert property (disable iff (rst)
        acc_rd_fs
        |=> (rdata[14:0] == 15'h4000) == fullscale_at_nominal)
        else $error("nominal flag disagrees with read");

    // the monotonic view drops the low steps that may fold back
    a_mono_bits: assert property (disable iff (rst)
        1'b1
        |-> offset_magnitude_mono[11:3] == offset_magnitude[11:3])
        else $error("monotonic view wrong");

    a_mono_low_zero: assert property (disable iff (rst)
        1'b1
        |-> offset_magnitude_mono[2:0] == 3'h0)
        else $error("monotonic view low bits set");

    a_mono_write: assert property (disable iff (rst)
        acc_wr_ofs
        |=> offset_magnitude_mono[11:3] == $past(wdata[11:3]))
        else $error("monotonic view missed write");

    // main scenarios
    c_write_offset: cover property (@(posedge clk_sys) acc_wr_ofs);
    c_write_fs: cover property (@(posedge clk_sys) acc_wr_fs);
    c_neg_offset: cover property (@(posedge clk_sys) offset_sign);
    c_read_fs: cover property (@(posedge clk_sys) acc_rd_fs);
    c_frozen_write: cover property (@(posedge clk_sys) !clk_en && wr_en);
endmodule

// ### cogt_trim_regs_tb.sv
// testbench for the channel offset and full-scale trim bank
`timescale 1ns/1ps
module cogt_trim_regs_tb;
    import cogt_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    cogt_addr_t addr = 4'h0;
    cogt_word_t wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    cogt_word_t rdata;
    logic offset_sign;
    logic [11:0] offset_magnitude;
    logic [11:0] offset_magnitude_mono;
    logic [14:0] fullscale_code;
    logic fullscale_at_nominal;
    int error_cnt = 0;
    int cmp_count = 0;
    always #2.5 clk_sys = ~clk_sys;
    cogt_trim_regs dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .offset_sign(offset_sign),
        .offset_magnitude(offset_magnitude),
        .offset_magnitude_mono(offset_magnitude_mono),
        .fullscale_code(fullscale_code),
        .fullscale_at_nominal(fullscale_at_nominal));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input cogt_addr_t a, input cogt_word_t d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input cogt_addr_t a, input cogt_word_t exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk_sys);
        #1;
        chk(rdata, 16'h0000);
    endtask
    // fs word carries the nominal flag in bit 15
    task automatic trims(input logic [15:0] ofs, input logic [15:0] fs);
        chk({3'h0, offset_sign, offset_magnitude}, ofs & 16'h1FFF);
        chk({4'h0, offset_magnitude_mono}, ofs & 16'h0FF8);
        chk({fullscale_at_nominal, fullscale_code}, fs);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #5000;
        error_cnt++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        trims(16'h0000, 16'hC000);
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h4000);
        $display("test reset values done");
        wr(4'h2, 16'h1FFF);
        trims(16'h1FFF, 16'hC000);
        wr(4'h3, 16'h7FFF);
        trims(16'h1FFF, 16'h7FFF);
        rd(4'h2, 16'h1FFF);
        rd(4'h3, 16'h7FFF);
        $display("test write extremes done");
        wr(4'h5, 16'h1234);
        rd(4'h5, 16'h0000);
        @(posedge clk_sys) clk_en <= 1'b0;
        wr(4'h2, 16'h0800);
        @(posedge clk_sys) clk_en <= 1'b1;
        #1;
        trims(16'h1FFF, 16'h7FFF);
        $display("test unmapped and frozen done");
        wr(4'h2, 16'h0800);
        rd(4'h2, 16'h0800);
        wr(4'h3, 16'h4000);
        trims(16'h0800, 16'hC000);
        wr(4'h3, 16'h0000);
        trims(16'h0800, 16'h0000);
        rd(4'h3, 16'h0000);
        $display("test midscale done");
        @(posedge clk_sys) rst <= 1'b1;
        @(posedge clk_sys) rst <= 1'b0;
        #1;
        trims(16'h0000, 16'hC000);
        rd(4'h3, 16'h4000);
        $display("test mid-run reset done");
        results();
    end
endmodule
